//--- src/dtc_pkg.sv
package dtc_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_TMR = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 2'h2;
  localparam logic [DATA_W-1:0] TMR_RST = 8'h00;
  localparam logic [DATA_W-1:0] CFG_RST = 8'h00;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int RTT_W = 3;
  localparam int TMR_RTT_LSB = 0;
  localparam int TMR_EN_BIT = 3;
  localparam int TMR_CA_LSB = 4;
  localparam int BAND_W = 3;
  localparam int CFG_BAND_LSB = 0;
  localparam int CFG_SETB_BIT = 3;
  localparam int CFG_BL32_BIT = 4;
  localparam int ST_DQ_BIT = 0;
  localparam int ST_DQS_BIT = 1;
  localparam int ST_CA_BUSY_BIT = 2;
  localparam int ST_LAT_OK_BIT = 3;
  localparam logic [RTT_W-1:0] RTT_OFF = 3'h0;
  localparam logic [RTT_W-1:0] RTT_240 = 3'h1;
  localparam logic [RTT_W-1:0] RTT_40 = 3'h6;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int MCLK_PERIOD_PS = 40000;
  localparam int CA_UPD_NS = 20;
  localparam int CA_UPD_CYC_I =
    (CA_UPD_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam int CA_CNT_W = 4;
  localparam logic [CA_CNT_W-1:0] CA_UPD_CYC =
    CA_CNT_W'((CA_UPD_CYC_I < 1) ? 1 : CA_UPD_CYC_I);
  localparam int LAT_W = 6;
  localparam logic [LAT_W-1:0] BL32_EXTRA = 6'h08;
  localparam logic [LAT_W-1:0] LAT_NONE = 6'h00;

  // Latency tables, index = band (0: up to 266 MHz ... 7: up to 2133)
  localparam logic [7:0][LAT_W-1:0] LON_A =
    {6'h08, 6'h06, 6'h06, 6'h04, 6'h04, 6'h00, 6'h00, 6'h00};
  localparam logic [7:0][LAT_W-1:0] LON_B =
    {6'h18, 6'h14, 6'h12, 6'h0E, 6'h0C, 6'h06, 6'h00, 6'h00};
  localparam logic [7:0][LAT_W-1:0] LOFF_A =
    {6'h1C, 6'h1A, 6'h18, 6'h16, 6'h14, 6'h00, 6'h00, 6'h00};
  localparam logic [7:0][LAT_W-1:0] LOFF_B =
    {6'h2C, 6'h28, 6'h24, 6'h20, 6'h1C, 6'h16, 6'h00, 6'h00};

endpackage

//--- src/dtc_lat_lut.sv
// Latency lookup by band, latency set and burst length
module dtc_lat_lut
(
  input wire logic [dtc_pkg::BAND_W-1:0] band,
  input wire logic set_b,
  input wire logic bl32,
  output logic [dtc_pkg::LAT_W-1:0] lat_on,
  output logic [dtc_pkg::LAT_W-1:0] lat_off,
  output logic lat_ok
);

  import dtc_pkg::*;

  logic [LAT_W-1:0] off_base;

  // ------------------------------------------------------------------
  // Table select
  // ------------------------------------------------------------------
  // A zero entry marks a band with no defined latency
  always_comb
  begin
    lat_on = set_b ? LON_B[band] : LON_A[band];
    off_base = set_b ? LOFF_B[band] : LOFF_A[band];
    lat_ok = (lat_on != LAT_NONE);
    lat_off = bl32 ? LAT_W'(off_base + BL32_EXTRA) : off_base;
  end

endmodule

//--- src/dtc_top.sv
// Termination control for the data and command/address lines
module dtc_top
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [dtc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dtc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dtc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic wr1_cmd,
  input wire logic mwr1_cmd,
  input wire logic power_down,
  input wire logic self_refresh,
  input wire logic write_leveling,
  output logic dq_term_en,
  output logic dqs_term_en,
  output logic [dtc_pkg::RTT_W-1:0] termination_resistance,
  output logic [dtc_pkg::RTT_W-1:0] ca_term_setting,
  output logic ca_update_busy
);

  import dtc_pkg::*;

  logic [DATA_W-1:0] tmr_reg;
  logic [DATA_W-1:0] cfg_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [RTT_W-1:0] ca_set_reg;
  logic [RTT_W-1:0] ca_stage_reg;
  logic [CA_CNT_W-1:0] ca_cnt_reg;
  logic ca_busy_reg;
  logic [LAT_W-1:0] on_cnt_reg;
  logic [LAT_W-1:0] off_cnt_reg;
  logic burst_reg;
  logic burst_next;
  logic dq_reg;
  logic dqs_reg;
  logic [RTT_W-1:0] rtt_reg;
  logic [LAT_W-1:0] lat_on;
  logic [LAT_W-1:0] lat_off;
  logic lat_ok;
  logic cmd_go;
  logic mode_en;
  logic rtt_valid;
  logic [RTT_W-1:0] rtt_code;
  logic quiet;
  logic [DATA_W-1:0] stat_word;

  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------
  // Bit 3 alone decides enable; the field can still be zero with it set
  assign mode_en = tmr_reg[TMR_EN_BIT];
  assign rtt_code = tmr_reg[TMR_RTT_LSB +: RTT_W];
  // Reserved codes 000 and 111 leave the lines unterminated
  assign rtt_valid = (rtt_code >= RTT_240) && (rtt_code <= RTT_40);
  // Power-down and self-refresh force both enables off in every mode; the resistance code is not gated
  assign quiet = power_down | self_refresh;
  // Either write flavour arriving in its second command cycle
  assign cmd_go = (wr1_cmd | mwr1_cmd) & mode_en & lat_ok;

  // ------------------------------------------------------------------
  // Latency lookup
  // ------------------------------------------------------------------
  dtc_lat_lut u_lut (
    .band(cfg_reg[CFG_BAND_LSB +: BAND_W]),
    .set_b(cfg_reg[CFG_SETB_BIT]),
    .bl32(cfg_reg[CFG_BL32_BIT]),
    .lat_on(lat_on),
    .lat_off(lat_off),
    .lat_ok(lat_ok)
  );

  // ------------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------------
  // Mode and configuration registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tmr_reg <= TMR_RST;
      cfg_reg <= CFG_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_TMR)
        tmr_reg <= reg_wdata;
      if (reg_addr == ADDR_CFG)
        cfg_reg <= reg_wdata;
    end
  end

  // CA setting is staged and applied after the update time
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ca_stage_reg <= RTT_OFF;
      ca_set_reg <= RTT_OFF;
      ca_cnt_reg <= '0;
      ca_busy_reg <= 1'b0;
    end
    else if (reg_wr && (reg_addr == ADDR_TMR))
    begin
      // A second write restarts the wait for the newest value
      ca_stage_reg <= reg_wdata[TMR_CA_LSB +: RTT_W];
      ca_cnt_reg <= CA_UPD_CYC;
      ca_busy_reg <= 1'b1;
    end
    else if (ca_cnt_reg != '0)
    begin
      ca_cnt_reg <= ca_cnt_reg - 1'b1;
      // Busy flag kept in a flop so the pin has no logic behind it
      ca_busy_reg <= (ca_cnt_reg != CA_CNT_W'(1));
      if (ca_cnt_reg == CA_CNT_W'(1))
        ca_set_reg <= ca_stage_reg;
    end
    else
      ca_busy_reg <= 1'b0;
  end

  // ------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------
  // Live status of the termination outputs and pending CA update
  always_comb
  begin
    stat_word = '0;
    stat_word[ST_DQ_BIT] = dq_reg;
    stat_word[ST_DQS_BIT] = dqs_reg;
    stat_word[ST_CA_BUSY_BIT] = (ca_cnt_reg != '0);
    stat_word[ST_LAT_OK_BIT] = lat_ok;
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_reg <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_TMR: rdata_reg <= tmr_reg;
        ADDR_CFG: rdata_reg <= cfg_reg;
        ADDR_STAT: rdata_reg <= stat_word;
        default: rdata_reg <= '0;
      endcase
    end
    else
      rdata_reg <= '0;
  end

  // ------------------------------------------------------------------
  // Burst window counters
  // ------------------------------------------------------------------
  // The earliest pending write owns the turn-on point, so a later
  // write never pushes an earlier turn-on back
  always_ff @(posedge mclk)
  begin
    if (rst)
      on_cnt_reg <= '0;
    else if (cmd_go && (on_cnt_reg == '0) && !burst_reg)
      on_cnt_reg <= LAT_W'(lat_on - 1'b1);
    else if (on_cnt_reg != '0)
      on_cnt_reg <= on_cnt_reg - 1'b1;
  end

  // Each write pushes the turn-off point out to its own latency
  always_ff @(posedge mclk)
  begin
    if (rst)
      off_cnt_reg <= '0;
    else if (cmd_go)
      off_cnt_reg <= LAT_W'(lat_off - 1'b1);
    else if (off_cnt_reg != '0)
      off_cnt_reg <= off_cnt_reg - 1'b1;
  end

  // Window opens when the on count expires, closes on the off count
  always_comb
  begin
    burst_next = burst_reg;
    if (on_cnt_reg == LAT_W'(1))
      burst_next = 1'b1;
    if ((off_cnt_reg == LAT_W'(1)) && !cmd_go)
      burst_next = 1'b0;
    if (!mode_en)
      burst_next = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      burst_reg <= 1'b0;
    else
      burst_reg <= burst_next;
  end

  // ------------------------------------------------------------------
  // Termination switch
  // ------------------------------------------------------------------
  // Switch driven from the burst window, mode register and the power-down, self-refresh and write leveling pins
  // Gating inputs are same-clock state, seen one cycle late here
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dq_reg <= 1'b0;
      dqs_reg <= 1'b0;
      rtt_reg <= RTT_OFF;
    end
    else
    begin
      dq_reg <= burst_next & mode_en & rtt_valid & !quiet
        & !write_leveling;
      dqs_reg <= (burst_next | write_leveling) & mode_en & rtt_valid
        & !quiet;
      rtt_reg <= (mode_en && rtt_valid) ? rtt_code : RTT_OFF;
    end
  end

  assign dq_term_en = dq_reg;
  assign dqs_term_en = dqs_reg;
  assign termination_resistance = rtt_reg;
  assign ca_term_setting = ca_set_reg;
  assign ca_update_busy = ca_busy_reg;
  assign reg_rdata = rdata_reg;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_tmr_write;
    reg_wr && (reg_addr == ADDR_TMR);
  endsequence

  sequence s_idle_cmd4;
    cmd_go && (lat_on == 6'h04) && (on_cnt_reg == '0) && !burst_reg;
  endsequence

  sequence s_ca_last;
    (ca_cnt_reg == CA_CNT_W'(1)) && !(reg_wr && (reg_addr == ADDR_TMR));
  endsequence

  a_ca_update_delay: assert property (
    s_tmr_write ##1 !(reg_wr && (reg_addr == ADDR_TMR))
      |=> ca_set_reg == $past(reg_wdata[TMR_CA_LSB +: RTT_W], 2))
    else $error("CA termination not applied after update time");

  a_ca_hold_busy: assert property (
    s_tmr_write |=> ca_update_busy && $stable(ca_set_reg))
    else $error("CA termination changed before update time");

  a_quiet_off: assert property (
    $past(quiet) |-> !dq_term_en && !dqs_term_en)
    else $error("Termination on during power-down or self-refresh");

  a_wl_dq_off: assert property (
    $past(write_leveling) |-> !dq_term_en)
    else $error("DQ termination on during write leveling");

  a_wl_dqs_on: assert property (
    write_leveling && !quiet && mode_en && rtt_valid |=> dqs_term_en)
    else $error("Strobe termination off during write leveling");

  a_disabled_off: assert property (
    !$past(mode_en) |-> !dq_term_en && !dqs_term_en)
    else $error("Termination on while mode disabled");

  a_on_latency: assert property (
    s_idle_cmd4 ##1 mode_en[*4] |-> !$past(burst_reg) && burst_reg)
    else $error("Turn-on not four clocks after command");

  a_off_load: assert property (
    cmd_go |=> off_cnt_reg == LAT_W'($past(lat_off) - 1'b1))
    else $error("Turn-off count not loaded from latency");

  a_off_close: assert property (
    (off_cnt_reg == LAT_W'(1)) && !cmd_go |=> !burst_reg ##1 !dq_term_en)
    else $error("Termination not released after burst");

  a_rtt_code: assert property (
    dq_term_en |-> termination_resistance == $past(rtt_code))
    else $error("Resistance code does not follow the field");

  a_no_cmd_off: assert property (
    !burst_reg && (on_cnt_reg == '0) && !cmd_go |=> !burst_reg)
    else $error("Termination opened without a write");

  a_on_load: assert property (
    cmd_go && (on_cnt_reg == '0) && !burst_reg
      |=> on_cnt_reg == LAT_W'($past(lat_on) - 1'b1))
    else $error("Turn-on count not loaded from latency");

  a_ca_busy_drop: assert property (
    s_ca_last |=> !ca_update_busy && (ca_set_reg == $past(ca_stage_reg)))
    else $error("CA update not finished on the last count");

  a_rtt_off: assert property (
    !mode_en |=> termination_resistance == RTT_OFF)
    else $error("Resistance code shown while mode disabled");

  a_rtt_follow: assert property (
    mode_en && rtt_valid |=> termination_resistance == $past(rtt_code))
    else $error("Resistance code not taken from the field");

  a_dq_with_dqs: assert property (
    dq_term_en |-> dqs_term_en)
    else $error("DQ termination on without strobe termination");

  a_wl_dqs_off: assert property (
    write_leveling && !(mode_en && rtt_valid) |=> !dqs_term_en)
    else $error("Strobe termination on in write leveling while disabled");

  a_tmr_write: assert property (
    s_tmr_write |=> tmr_reg == $past(reg_wdata))
    else $error("Mode register write not taken");

  a_cfg_write: assert property (
    reg_wr && (reg_addr == ADDR_CFG) |=> cfg_reg == $past(reg_wdata))
    else $error("Configuration write not taken");

  a_read_mode: assert property (
    reg_rd && (reg_addr == ADDR_TMR) |=> reg_rdata == $past(tmr_reg))
    else $error("Mode register read back wrong");

  a_stat_read: assert property (
    reg_rd && (reg_addr == ADDR_STAT)
      |=> reg_rdata[ST_LAT_OK_BIT] == $past(lat_ok))
    else $error("Latency valid flag read back wrong");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == '0)
    else $error("Read data not cleared outside a read");

endmodule

//--- verification/dtc_ctrl_model.sv
// -----------------------------------------------------------------------
// Host side: issues decoded write commands toward the termination block
// -----------------------------------------------------------------------
module dtc_ctrl_model
(
  input wire logic mclk,
  input wire logic req,
  input wire logic mask,
  input wire logic [3:0] gap,
  output logic wr1_cmd,
  output logic mwr1_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m;

  // One-cycle command pulse; gap models a slow host, mask picks masked
  initial
  begin
    wr1_cmd = 1'b0;
    mwr1_cmd = 1'b0;
    forever
    begin
      @(posedge mclk);
      if (req)
      begin
        m = mask;
        repeat (gap) @(posedge mclk);
        wr1_cmd <= !m;
        mwr1_cmd <= m;
        @(posedge mclk);
        wr1_cmd <= 1'b0;
        mwr1_cmd <= 1'b0;
      end
    end
  end
endmodule

//--- verification/tb_dtc_top.sv
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_dtc_top;
  import dtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [4:0] v; int c;} dtc_note_t;
  logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, n8;
  logic power_down = 1'b0, self_refresh = 1'b0, write_leveling = 1'b0;
  logic req = 1'b0, mask = 1'b0, rd_d1 = 1'b0;
  logic [3:0] gap = '0;
  logic dq_term_en, dqs_term_en, ca_update_busy, wr1_cmd, mwr1_cmd;
  logic [RTT_W-1:0] termination_resistance, ca_term_setting, r;
  logic [31:0] seed = 32'h8516;
  int cyc = 0, bad_count = 0, n_tests = 0, on, off;
  int lon_a[8] = '{0, 0, 0, 4, 4, 6, 6, 8};
  int lon_b[8] = '{0, 0, 6, 12, 14, 18, 20, 24};
  int loff_a[8] = '{0, 0, 0, 20, 22, 24, 26, 28};
  int loff_b[8] = '{0, 0, 22, 28, 32, 36, 40, 44};
  dtc_note_t edge_q[$], n;
  logic [DATA_W-1:0] rd_q[$];

  dtc_top u_dtc_top (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wr1_cmd(wr1_cmd), .mwr1_cmd(mwr1_cmd),
    .power_down(power_down), .self_refresh(self_refresh),
    .write_leveling(write_leveling), .dq_term_en(dq_term_en),
    .dqs_term_en(dqs_term_en),
    .termination_resistance(termination_resistance),
    .ca_term_setting(ca_term_setting), .ca_update_busy(ca_update_busy));
  dtc_ctrl_model u_dtc_ctrl_model (.mclk(mclk), .req(req), .mask(mask),
    .gap(gap), .wr1_cmd(wr1_cmd), .mwr1_cmd(mwr1_cmd));

  // -------------------------------------------------------------------
  // Clock, cycle count, watchers
  // -------------------------------------------------------------------
  initial
  begin
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk)
  begin
    if (rd_d1)
    begin
      n8 = rd_q.pop_front();
      `CHK(reg_rdata, n8)
    end
    rd_d1 <= reg_rd;
  end

  // Every termination edge must match the oldest note's value, and its cycle when the note gives one
  always @(dq_term_en or dqs_term_en)
  begin
    if (!rst)
    begin
      #1;
      if (edge_q.size() == 0)
      begin
        bad_count++;
        $display("wrong value t=%0t got %h exp %h", $time, dq_term_en, 1'b0);
      end
      else
      begin
        n = edge_q.pop_front();
        `CHK({dqs_term_en, dq_term_en, termination_resistance}, n.v)
        if (n.c >= 0) `CHK(cyc, n.c)
      end
    end
  end

  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask

  // Ask the host for a write; zero latency means no edge is expected
  task automatic wcmd(input logic m, input logic [3:0] g, input int lo,
    input int lf, input logic [2:0] c);
    int c0;
    @(posedge mclk);
    req <= 1'b1;
    mask <= m;
    gap <= g;
    @(posedge mclk);
    req <= 1'b0;
    for (int k = 0; k < 30; k++)
    begin
      @(posedge mclk);
      if (wr1_cmd | mwr1_cmd) break;
    end
    c0 = cyc;
    if (lo != 0) edge_q.push_back('{{2'h3, c}, c0 + lo});
    if (lf != 0) edge_q.push_back('{{2'h0, c}, c0 + lf});
  endtask

  task automatic wrap_up();
    if (edge_q.size() != 0) bad_count++;
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog sized well above the expected run of a few thousand cycles
  initial
  begin
    #800000;
    bad_count++;
    wrap_up();
  end

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_TMR, 8'h00);
    rd(ADDR_CFG, 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    wr(ADDR_STAT, 8'hFF);
    rd(ADDR_STAT, 8'h00);
    wr(ADDR_TMR, 8'h50);
    #1 `CHK({ca_update_busy, ca_term_setting}, 4'h8)
    @(posedge mclk);
    #1 `CHK({ca_update_busy, ca_term_setting}, 4'h5)
    rd(ADDR_TMR, 8'h50);
    for (int b = 2; b < 8; b++)
      for (int s = 0; s < 2; s++)
        for (int l = 0; l < 2; l++)
        begin
          seed = xs();
          r = 3'(seed % 6 + 1);
          on = s ? lon_b[b] : lon_a[b];
          off = (s ? loff_b[b] : loff_a[b]) + (on ? 8 * l : 0);
          wr(ADDR_CFG, 8'({1'(l), 1'(s), 3'(b)}));
          wr(ADDR_TMR, {4'h0, 1'b1, r});
          rd(ADDR_TMR, {4'h0, 1'b1, r});
          rd(ADDR_STAT, {4'h0, on != 0, 3'h0});
          wcmd(seed[8], seed[11:10], on, on ? off : 0, r);
          repeat (60) @(posedge mclk);
        end
    wr(ADDR_CFG, 8'h03);
    wr(ADDR_TMR, 8'h0C);
    wcmd(1'b0, 4'h0, 4, 0, 3'h4);
    wcmd(1'b1, 4'h0, 0, 20, 3'h4);
    repeat (40) @(posedge mclk);
    for (int i = 1; i < 3; i++)
    begin
      {self_refresh, power_down} <= 2'(i);
      repeat (3) @(posedge mclk);
      wcmd(1'b0, 4'h0, 0, 0, 3'h0);
      repeat (30) @(posedge mclk);
      {self_refresh, power_down} <= 2'h0;
      @(posedge mclk);
    end
    wr(ADDR_TMR, 8'h05);
    wcmd(1'b0, 4'h0, 0, 0, 3'h0);
    repeat (30) @(posedge mclk);
    wr(ADDR_TMR, 8'h0A);
    edge_q.push_back('{5'h12, -1});
    write_leveling <= 1'b1;
    repeat (10) @(posedge mclk);
    edge_q.push_back('{5'h02, -1});
    write_leveling <= 1'b0;
    repeat (10) @(posedge mclk);
    wr(ADDR_TMR, 8'h02);
    write_leveling <= 1'b1;
    repeat (10) @(posedge mclk);
    write_leveling <= 1'b0;
    repeat (10) @(posedge mclk);
    wrap_up();
  end
endmodule
